// ===== dv/puta_tb_top.sv
// puta_tb_top: register-driven tests of the unlisted-tag action block
// assumes the block's top with a short tick and the uart sink model on its stream
module puta_tb_top;
  import puta_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tx_data;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, gp_output_en;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_valid, tx_ready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        gp_output_0, gp_output_1, gp_output_2, gp_output_3, polling_active, poll_restart;
  int          err_count = 0, num_checks = 0, cyc = 0;
  // pwm cases: channel, duty, period, expected {pwm_on, period_ok, duty_ok}
  localparam logic [7:0]  PCH[7] = '{8'h01, 8'h02, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03};
  localparam logic [7:0]  PDT[7] = '{8'h32, 8'h63, 8'h00, 8'h64, 8'h32, 8'h32, 8'h32};
  localparam logic [23:0] PPR[7] = '{24'h000006, 24'h2F9E78, 24'h000064, 24'h000064, 24'h000005, 24'h2F9E79,
                                     24'h000064};
  localparam logic [2:0]  PST[7] = '{3'b111, 3'b111, 3'b010, 3'b010, 3'b001, 3'b001, 3'b011};
  ////////////////////////////////////////////////////////////////////////////////
  puta_top #(.TICK_CYCLES(10)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_data, .tx_valid, .tx_ready, .gp_output_0, .gp_output_1, .gp_output_2, .gp_output_3, .gp_output_en,
    .polling_active, .poll_restart);
  puta_uart_sink sink_u (.aclk, .aresetn, .tx_data, .tx_valid, .tx_ready, .slow);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // both tasks start right after a rising edge and change signals only by nonblocking assignment
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rexp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, rexp, "bresp");
    s_axi_bready <= 1'b0;
    // an idle edge, so a following call never raises bready in the same step
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] rexp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    chk(s_axi_rresp, rexp, "rresp");
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always #5 aclk = ~aclk;
  // the whole run needs under 3k cycles, so 20k means a hang
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    logic [31:0] d;
    logic [7:0]  exp_q[$];
    int          n;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(PUTA_ADDR_RESULT, d, 2'h0);
    chk(d[7:0], 8'hFF, "result at reset");
    axi_rd(8'h40, d, 2'h2);
    chk(d, 32'h0, "unmapped read");
    axi_wr(8'h40, 32'h0, 2'h2);
    $display("test reset done");
    for (int f = 0; f < 4; f++) begin
      slow <= (f == 3);
      axi_wr(PUTA_ADDR_ARG0, {8'h32, 8'h03, 4'h5, 4'(f + 4), 8'(f)}, 2'h0);
      axi_wr(PUTA_ADDR_ARG1, {8'h03, 24'h000064}, 2'h0);
      axi_wr(PUTA_ADDR_UID, 32'h44332211, 2'h0);
      axi_wr(PUTA_ADDR_CMD, {24'h0, PUTA_CMD_POLLING}, 2'h0);
      axi_rd(PUTA_ADDR_RESULT, d, 2'h0);
      chk(d[7:0], PUTA_RESULT_OK, "result");
      sink_u.rx_q.delete();
      axi_wr(PUTA_ADDR_EVENT, 32'h0000_0401, 2'h0);
      n = 0;
      while (poll_restart !== 1'b1 && n < 2000) begin
        @(posedge aclk);
        n++;
      end
      chk(poll_restart, 1'b1, "restart");
      if (f == 0) chk(n >= 27 && n <= 33, 1'b1, "wait length");
      chk(gp_output_en, 4'h5, "io enable");
      chk({gp_output_3, gp_output_2, gp_output_1, gp_output_0}, {3'b010, 1'(f)}, "io level");
      case (f)
        1: exp_q = '{PUTA_ASYNC_HDR, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44};
        2: exp_q = '{8'h04, 8'h11, 8'h22, 8'h33, 8'h44};
        3: exp_q = '{8'h34, 8'h31, 8'h31, 8'h32, 8'h32, 8'h33, 8'h33, 8'h34, 8'h34, PUTA_CHAR_CR, PUTA_CHAR_LF};
        default: exp_q = {};
      endcase
      chk(sink_u.rx_q.size(), exp_q.size(), "byte count");
      foreach (exp_q[i]) chk(sink_u.rx_q[i], exp_q[i], "report byte");
      @(posedge aclk);
      $display("test format %0d done", f);
    end
    // reset in mid-run while polling is on
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(polling_active, 1'b0, "polling after reset");
    chk(gp_output_en, 4'h0, "enables after reset");
    axi_rd(PUTA_ADDR_RESULT, d, 2'h0);
    chk(d[7:0], 8'hFF, "result after reset");
    $display("test mid reset done");
    for (int i = 0; i < 7; i++) begin
      axi_wr(PUTA_ADDR_ARG0, {PDT[i], PCH[i], 8'h00, PUTA_FMT_NONE}, 2'h0);
      axi_wr(PUTA_ADDR_ARG1, {8'hFF, PPR[i]}, 2'h0);
      axi_wr(PUTA_ADDR_CMD, {24'h0, PUTA_CMD_POLLING}, 2'h0);
      axi_wr(PUTA_ADDR_EVENT, 32'h0000_0401, 2'h0);
      if (i == 0) begin
        // first high phase of a 6 us period at 50 percent on output 1
        n = 0;
        while (gp_output_1 !== 1'b1 && n < 2000) begin
          @(posedge aclk);
          n++;
        end
        n = 0;
        while (gp_output_1 === 1'b1 && n < 2000) begin
          @(posedge aclk);
          n++;
        end
        chk(n, 300, "pwm high time");
      end
      axi_rd(PUTA_ADDR_STATUS, d, 2'h0);
      chk(d[7:5], PST[i], "pwm status");
      chk(gp_output_en, PST[i][2] ? 4'(1 << PCH[i]) : 4'h0, "pwm route");
      axi_wr(PUTA_ADDR_CMD, 32'h0000_0001, 2'h0);
      chk(polling_active, 1'b0, "abort");
      $display("test pwm case %0d done", i);
    end
    axi_wr(PUTA_ADDR_EVENT, 32'h0000_0401, 2'h0);
    axi_rd(PUTA_ADDR_STATUS, d, 2'h0);
    chk(d[4:2], 3'b000, "event ignored when stopped");
    $display("test stopped done");
    give_verdict();
  end
endmodule

// ===== dv/puta_top_props.sv
// puta_top_props: concurrent checks on the ports of the unlisted-tag action block
// assumes one clock domain, aclk with synchronous active-low aresetn
module puta_props (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // uart stream
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  // outputs and polling
  input wire logic [3:0] gp_output_en,
  input wire logic       polling_active,
  input wire logic       poll_restart
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence tx_stall_s;
    tx_valid && !tx_ready;
  endsequence
  sequence tx_held_s;
    tx_valid && $stable(tx_data);
  endsequence
  tx_hold_a: assert property (tx_stall_s |=> tx_held_s)
    else $error("uart byte changed before accept");
  restart_pulse_a: assert property (poll_restart |=> !poll_restart)
    else $error("restart lasted more than one cycle");
  restart_quiet_a: assert property (poll_restart |-> !tx_valid)
    else $error("restart while a report byte is pending");
  tx_polling_a: assert property (tx_valid |-> polling_active)
    else $error("report byte while polling is off");
  restart_polling_a: assert property (poll_restart |-> polling_active)
    else $error("restart while polling is off");
  stop_quiet_a: assert property ($fell(polling_active) |-> !poll_restart && !tx_valid)
    else $error("activity left after polling stopped");
  en_stable_a: assert property (tx_valid && $past(tx_valid) |-> $stable(gp_output_en))
    else $error("output enables moved during a report");
  rst_quiet_a: assert property ($rose(aresetn) |-> gp_output_en == 4'h0 && !polling_active)
    else $error("outputs not idle after reset");
endmodule
bind puta_top puta_props chk_u (.aclk, .aresetn, .tx_data, .tx_valid, .tx_ready, .gp_output_en,
  .polling_active, .poll_restart);

// ===== dv/puta_uart_sink.sv
// puta_uart_sink: byte sink standing in for the uart transmitter behind the block
// assumes tx_data and tx_valid hold until tx_ready is sampled high
module puta_uart_sink (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // byte stream
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // pacing
  input  wire logic       slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  // slow pacing accepts every other cycle so the sender has to hold its byte
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_ready <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) begin
        rx_q.push_back(tx_data);
      end
      tx_ready <= slow ? !tx_ready : 1'b1;
    end
  end
endmodule

// ===== hdl/puta_pkg.sv
// puta_pkg: constants shared by the unlisted-tag action block
// assumes a 100 MHz aclk and a 32-bit AXI4-Lite register port
package puta_pkg;
  // register byte addresses
  localparam logic [7:0] PUTA_ADDR_ARG0   = 8'h00;  // format, io cfg, pwm chan, duty
  localparam logic [7:0] PUTA_ADDR_ARG1   = 8'h04;  // period [23:0], timeout [31:24]
  localparam logic [7:0] PUTA_ADDR_CMD    = 8'h08;  // write: command code
  localparam logic [7:0] PUTA_ADDR_EVENT  = 8'h0C;  // write: tag event + uid length
  localparam logic [7:0] PUTA_ADDR_UID    = 8'h10;  // uid bytes 0..3
  localparam logic [7:0] PUTA_ADDR_STATUS = 8'h14;  // read only
  localparam logic [7:0] PUTA_ADDR_RESULT = 8'h18;  // read only
  // argument byte offsets inside the command parameter area
  localparam logic [7:0] PUTA_OFS_FORMAT  = 8'h0A;
  localparam logic [7:0] PUTA_OFS_TIMEOUT = 8'h11;
  // commands
  localparam logic [7:0] PUTA_CMD_POLLING = 8'h22;
  localparam logic [7:0] PUTA_RESULT_OK   = 8'h00;
  // report formats
  localparam logic [7:0] PUTA_FMT_NONE    = 8'h00;
  localparam logic [7:0] PUTA_FMT_ASYNC   = 8'h01;
  localparam logic [7:0] PUTA_FMT_BINARY  = 8'h02;
  localparam logic [7:0] PUTA_FMT_STRING  = 8'h03;
  localparam logic [7:0] PUTA_PWM_MAXCH   = 8'h02;
  localparam logic [7:0] PUTA_DUTY_MAX    = 8'h64;
  localparam logic [23:0] PUTA_PERIOD_MIN = 24'h000005;
  localparam logic [23:0] PUTA_PERIOD_MAX = 24'h2F9E79;
  // async packet header byte, value is arbitrary
  localparam logic [7:0] PUTA_ASYNC_HDR   = 8'hA5;
  localparam logic [7:0] PUTA_CHAR_CR     = 8'h0D;
  localparam logic [7:0] PUTA_CHAR_LF     = 8'h0A;
  localparam logic [7:0] PUTA_CHAR_0      = 8'h30;
  localparam logic [7:0] PUTA_CHAR_A      = 8'h37;  // 'A' - 10
  // timing
  localparam int PUTA_CLK_HZ        = 100_000_000;
  localparam int PUTA_US_NS         = 1000;
  localparam int PUTA_CLK_NS        = 10;
  localparam int PUTA_CYC_PER_US    = PUTA_US_NS / PUTA_CLK_NS;
  localparam int PUTA_TICK_MS       = 100;
  localparam int PUTA_CYC_PER_TICK  = PUTA_CLK_HZ / 1000 * PUTA_TICK_MS;
  localparam int PUTA_UID_BYTES     = 4;
  // io config field positions
  localparam int PUTA_IO_EN_LSB     = 4;
  localparam int PUTA_IO_LVL_LSB    = 0;
  localparam int PUTA_NUM_IO        = 4;
endpackage

// ===== hdl/puta_pwm.sv
// puta_pwm: pwm wave from period in microseconds and duty in percent
// assumes validated settings; restarts whenever run drops
module puta_pwm
  import puta_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // settings
  puta_pwm_if.gen   pwm
);
  logic [6:0]  us_cnt;
  logic [23:0] pos_us;
  logic [31:0] high_us;
  wire         us_tick = (us_cnt == 7'(PUTA_CYC_PER_US - 1));
  wire         wrap    = us_tick && (pos_us >= pwm.period_us - 24'h000001);
  // duty in percent scaled to microseconds; truncation keeps the high time short
  assign high_us = (32'(pwm.period_us) * 32'(pwm.duty)) / 32'(PUTA_DUTY_MAX);

  always_ff @(posedge aclk) begin
    if (!aresetn || !pwm.run) begin
      us_cnt <= '0;
      pos_us <= '0;
      pwm.wave <= 1'b0;
    end else begin
      us_cnt <= us_tick ? '0 : us_cnt + 7'h01;
      if (wrap) pos_us <= '0;
      else if (us_tick) pos_us <= pos_us + 24'h000001;
      pwm.wave <= (32'(pos_us) < high_us);
    end
  end
endmodule

// ===== hdl/puta_pwm_if.sv
// puta_pwm_if: pwm settings carried from the decoder to the pwm generator
// assumes one clock domain
interface puta_pwm_if;
  logic        run;
  logic [7:0]  duty;
  logic [23:0] period_us;
  logic        wave;
  modport ctrl (output run, output duty, output period_us, input wave);
  modport gen  (input run, input duty, input period_us, output wave);
endinterface

// ===== hdl/puta_top.sv
// puta_top: unlisted-tag argument decoder and action logic of the polling command
// assumes an axi4-lite master, a byte-wide uart transmitter with valid/ready,
// and a polling engine that raises tag events through the event register
module puta_top
  import puta_pkg::*;
#(
  parameter int TICK_CYCLES = PUTA_CYC_PER_TICK
)(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // uart byte stream
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  // general outputs
  output logic             gp_output_0,
  output logic             gp_output_1,
  output logic             gp_output_2,
  output logic             gp_output_3,
  output logic [3:0]       gp_output_en,
  // polling engine
  output logic             polling_active,
  output logic             poll_restart
);
  typedef enum {PUTA_IDLE, PUTA_HDR, PUTA_LEN, PUTA_UID, PUTA_CR, PUTA_LF, PUTA_WAIT} puta_state_t;

  function automatic logic [7:0] puta_hex(input logic [3:0] n);
    puta_hex = (n < 4'hA) ? PUTA_CHAR_0 + 8'(n) : PUTA_CHAR_A + 8'(n);
  endfunction

  logic [31:0] arg0, arg1, uid_reg;
  logic [7:0]  result, uid_len, idx;
  logic        hex_lo, tag_hit;
  logic [31:0] tick_cnt;
  logic [7:0]  ticks_left;
  logic        aw_held, w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  puta_state_t state, next_state;
  logic [3:0]  io_lvl;

  ////////////////////////////////////////////////////////////////////////
  // argument decode
  wire [7:0]  fmt       = arg0[7:0];
  wire [7:0]  io_cfg    = arg0[15:8];
  wire [7:0]  pwm_ch    = arg0[23:16];
  wire [7:0]  duty      = arg0[31:24];
  wire [23:0] period    = arg1[23:0];
  wire [7:0]  timeout   = arg1[31:24];
  wire [3:0]  io_en     = io_cfg[PUTA_IO_EN_LSB +: PUTA_NUM_IO];
  wire [3:0]  io_level  = io_cfg[PUTA_IO_LVL_LSB +: PUTA_NUM_IO];
  wire        duty_ok   = (duty != 8'h00) && (duty < PUTA_DUTY_MAX);
  wire        period_ok = (period > PUTA_PERIOD_MIN) && (period < PUTA_PERIOD_MAX);
  wire        pwm_on    = (pwm_ch <= PUTA_PWM_MAXCH) && duty_ok && period_ok;
  wire [7:0]  uid_byte  = uid_reg[8 * idx[1:0] +: 8];

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data taken in either order
  wire wr_go   = aw_held && w_held && !s_axi_bvalid;
  wire wr_hit  = (aw_addr == PUTA_ADDR_ARG0) || (aw_addr == PUTA_ADDR_ARG1) || (aw_addr == PUTA_ADDR_CMD) ||
                 (aw_addr == PUTA_ADDR_EVENT) || (aw_addr == PUTA_ADDR_UID);
  wire cmd_wr  = wr_go && (aw_addr == PUTA_ADDR_CMD) && w_data[7:0] != 8'h00;
  wire evt_wr  = wr_go && (aw_addr == PUTA_ADDR_EVENT) && w_data[0];
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;

  function automatic logic [31:0] puta_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) puta_merge[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
  endfunction
  logic [3:0] w_strb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // registers; argument words hold bytes 0x0A..0x11 in order, host fills them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arg0 <= 32'h0000_0000;
      arg1 <= 32'h0000_0000;
      uid_reg <= 32'h0000_0000;
      uid_len <= 8'h00;
      result  <= 8'hFF;
      polling_active <= 1'b0;
    end else if (wr_go) begin
      if (aw_addr == PUTA_ADDR_ARG0) arg0 <= puta_merge(arg0, w_data, w_strb);
      if (aw_addr == PUTA_ADDR_ARG1) arg1 <= puta_merge(arg1, w_data, w_strb);
      if (aw_addr == PUTA_ADDR_UID) uid_reg <= puta_merge(uid_reg, w_data, w_strb);
      if (evt_wr && state == PUTA_IDLE) uid_len <= (w_data[15:8] > 8'(PUTA_UID_BYTES)) ? 8'(PUTA_UID_BYTES) : w_data[15:8];
      if (cmd_wr) begin
        polling_active <= (w_data[7:0] == PUTA_CMD_POLLING);
        if (w_data[7:0] == PUTA_CMD_POLLING) result <= PUTA_RESULT_OK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case ({s_axi_araddr[7:2], 2'b00})
        PUTA_ADDR_ARG0:   s_axi_rdata <= arg0;
        PUTA_ADDR_ARG1:   s_axi_rdata <= arg1;
        PUTA_ADDR_UID:    s_axi_rdata <= uid_reg;
        PUTA_ADDR_STATUS: s_axi_rdata <= {24'h000000, pwm_on, period_ok, duty_ok, (state != PUTA_IDLE),
                                          tag_hit, polling_active, state == PUTA_WAIT, 1'b0};
        PUTA_ADDR_RESULT: s_axi_rdata <= {24'h000000, result};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  ////////////////////////////////////////////////////////////////////////
  // report sequencer
  wire tx_go     = tx_valid && tx_ready;
  wire last_uid  = (idx + 8'h01 >= uid_len);
  wire tick_done = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_comb begin
    next_state = state;
    case (state)
      PUTA_IDLE: if (evt_wr && polling_active) begin
        case (fmt)
          PUTA_FMT_ASYNC:  next_state = PUTA_HDR;
          PUTA_FMT_BINARY, PUTA_FMT_STRING: next_state = PUTA_LEN;
          default:         next_state = PUTA_WAIT;
        endcase
      end
      PUTA_HDR: if (tx_go) next_state = PUTA_LEN;
      PUTA_LEN: if (tx_go) next_state = (uid_len == 8'h00) ? PUTA_CR : PUTA_UID;
      PUTA_UID: if (tx_go && last_uid && (fmt != PUTA_FMT_STRING || hex_lo)) next_state = PUTA_CR;
      PUTA_CR:  if (fmt != PUTA_FMT_STRING) next_state = PUTA_WAIT;
                else if (tx_go) next_state = PUTA_LF;
      PUTA_LF:  if (tx_go) next_state = PUTA_WAIT;
      PUTA_WAIT: if (ticks_left == 8'h00) next_state = PUTA_IDLE;
      default:  next_state = PUTA_IDLE;
    endcase
  end

  assign tx_valid = (state == PUTA_HDR) || (state == PUTA_LEN) || (state == PUTA_UID) ||
                    ((state == PUTA_CR) && fmt == PUTA_FMT_STRING) || (state == PUTA_LF);
  always_comb begin
    case (state)
      PUTA_HDR: tx_data = PUTA_ASYNC_HDR;
      PUTA_LEN: tx_data = (fmt == PUTA_FMT_STRING) ? puta_hex(uid_len[3:0]) : uid_len;
      PUTA_UID: tx_data = (fmt == PUTA_FMT_STRING) ? puta_hex(hex_lo ? uid_byte[3:0] : uid_byte[7:4]) : uid_byte;
      PUTA_CR:  tx_data = PUTA_CHAR_CR;
      PUTA_LF:  tx_data = PUTA_CHAR_LF;
      default:  tx_data = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || (cmd_wr && state != PUTA_IDLE)) begin
      state <= PUTA_IDLE;
      idx <= 8'h00;
      hex_lo <= 1'b0;
      tick_cnt <= 32'h0000_0000;
      ticks_left <= 8'h00;
      tag_hit <= 1'b0;
    end else begin
      state <= next_state;
      if (state == PUTA_IDLE && next_state != PUTA_IDLE) begin
        idx <= 8'h00;
        hex_lo <= 1'b0;
        tag_hit <= 1'b1;
        ticks_left <= timeout;
        tick_cnt <= 32'h0000_0000;
      end
      if (state == PUTA_UID && tx_go) begin
        hex_lo <= (fmt == PUTA_FMT_STRING) ? !hex_lo : 1'b0;
        if (fmt != PUTA_FMT_STRING || hex_lo) idx <= idx + 8'h01;
      end
      if (state == PUTA_WAIT) begin
        tick_cnt <= tick_done ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        if (tick_done && ticks_left != 8'h00) ticks_left <= ticks_left - 8'h01;
      end
      if (next_state == PUTA_IDLE) tag_hit <= 1'b0;
    end
  end
  assign poll_restart = (state == PUTA_WAIT) && (ticks_left == 8'h00);

  ////////////////////////////////////////////////////////////////////////
  // outputs and pwm
  puta_pwm_if pwm_bus ();
  assign pwm_bus.run = pwm_on && tag_hit;
  assign pwm_bus.duty = duty;
  assign pwm_bus.period_us = period;
  puta_pwm u_pwm (.aclk(aclk), .aresetn(aresetn), .pwm(pwm_bus));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_lvl <= 4'h0;
      gp_output_en <= 4'h0;
    end else begin
      for (int i = 0; i < PUTA_NUM_IO; i++) begin
        gp_output_en[i] <= io_en[i] || (pwm_on && pwm_ch == 8'(i));
        io_lvl[i] <= (pwm_on && pwm_ch == 8'(i) && tag_hit) ? pwm_bus.wave :
                     (tag_hit && io_en[i]) ? io_level[i] : 1'b0;
      end
    end
  end
  assign gp_output_0 = io_lvl[0];
  assign gp_output_1 = io_lvl[1];
  assign gp_output_2 = io_lvl[2];
  assign gp_output_3 = io_lvl[3];
endmodule
